/* hw/tws_sync.sv */
// two-flop synchroniser for the bus pins
`timescale 1ns/1ps
module tws_sync #(
   parameter int unsigned W = 2
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;
   // reset to released-bus level
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         meta <= '1;
         q <= '1;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule : tws_sync

/* hw/tws_top.sv */
// two-wire unit: register file, byte slave, smart mode, master strobes
`timescale 1ns/1ps
module tws_top
   import tws_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [REG_AW-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe_n,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   input wire logic sleep_active,
   input wire logic sys_clk_ready,
   input wire logic mst_rx_done,
   input wire logic mst_tx_done,
   output logic mst_ack_go,
   output logic mst_ack_nack,
   output logic mst_repeat_start_cmd_go,
   output logic mst_stop_go,
   output logic mst_addr_go,
   output logic mst_flush,
   output logic fast_plus_mode,
   output logic slave_irq,
   output logic master_irq
);
   typedef struct packed {
      logic [7:0] timing;
      logic [7:0] dbg;
      logic [7:0] mctrl;
      logic mack;
      logic master_read_flag;
      logic master_write_flag;
      logic [7:0] master_baud_divider;
      logic [7:0] master_target_address;
      logic [7:0] master_data_reg;
      logic [7:0] sctrl;
      logic sack;
      logic slave_data_flag;
      logic addr_or_stop_flag;
      logic rxack;
      logic dir;
      logic ap;
      logic [7:0] slave_own_address;
      logic [7:0] slave_data_reg;
      logic [7:0] smask;
      logic [7:0] rdata;
      tws_state_t st;
      logic [3:0] bits;
      logic [7:0] shift;
      logic scl_p;
      logic sda_p;
      logic [7:0] hcnt;
      logic [7:0] scnt;
      logic wake_hold;
      logic sda_oe_n;
      logic scl_oe_n;
      logic ack_go;
      logic rep_go;
      logic stop_go;
      logic addr_go;
      logic flush;
      logic s_irq;
      logic m_irq;
   } tws_regs_t;

   tws_regs_t r;
   tws_regs_t n;
   logic scl_s;
   logic sda_s;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic addr_hit;
   logic want_oe_n;
   logic hold_req;
   logic [7:0] hold_cyc;
   logic [7:0] setup_cyc;
   logic wr_slave_data_reg;
   logic rd_slave_data_reg;
   logic rd_master_data_reg;
   logic m_ok;

   // slave side runs with or without sleep; master strobes and the slave wake stretch care
   tws_sync #(.W(2)) u_sync (
      .clock(clock),
      .rst_n(rst_n),
      .d({scl_in, sda_in}),
      .q({scl_s, sda_s})
   );

   always_comb begin
      n = r;
      scl_rise = scl_s & ~r.scl_p;
      scl_fall = ~scl_s & r.scl_p;
      start_det = scl_s & r.scl_p & r.sda_p & ~sda_s;
      stop_det = scl_s & r.scl_p & ~r.sda_p & sda_s;
      // mask bits widen the match; all-zero address is general call
      addr_hit = (((r.shift[7:1] ^ r.slave_own_address[7:1]) & ~r.smask[7:1]) == 7'h00) ||
         (r.shift[7:1] == 7'h00 && r.slave_own_address[0]);
      wr_slave_data_reg = reg_wr && reg_addr == A_SLAVE_DATA_REG;
      rd_slave_data_reg = reg_rd && reg_addr == A_SLAVE_DATA_REG;
      rd_master_data_reg = reg_rd && reg_addr == A_MASTER_DATA_REG;
      m_ok = r.mctrl[B_EN] && !sleep_active;
      unique case (r.timing[B_HOLD_LO +: 2])
         2'h0: hold_cyc = 8'h00;
         2'h1: hold_cyc = HOLD1_CYC;
         2'h2: hold_cyc = HOLD2_CYC;
         2'h3: hold_cyc = HOLD3_CYC;
      endcase
      setup_cyc = r.timing[B_SETUP] ? SETUP_LONG_CYC : SETUP_SHORT_CYC;
      n.scl_p = scl_s;
      n.sda_p = sda_s;
      n.rdata = 8'h00;
      n.ack_go = 1'b0;
      n.rep_go = 1'b0;
      n.stop_go = 1'b0;
      n.addr_go = 1'b0;
      n.flush = 1'b0;

      // register reads
      if (reg_rd) begin
         unique case (reg_addr)
            A_BUS_TIMING: n.rdata = r.timing;
            A_DEBUG_RUN: n.rdata = r.dbg;
            A_MCTRL_ONE: n.rdata = r.mctrl;
            A_MCTRL_TWO: n.rdata = 8'(r.mack) << B_ACK_ACTION;
            A_MASTER_STATUS_REG: n.rdata = {r.master_read_flag, r.master_write_flag, 6'h00};
            A_MASTER_BAUD_DIVIDER: n.rdata = r.master_baud_divider;
            A_MASTER_TARGET_ADDRESS: n.rdata = r.master_target_address;
            A_MASTER_DATA_REG: n.rdata = r.master_data_reg;
            A_SCTRL_ONE: n.rdata = r.sctrl;
            A_SCTRL_TWO: n.rdata = 8'(r.sack) << B_ACK_ACTION;
            A_SLAVE_STATUS_REG: n.rdata = {r.slave_data_flag, r.addr_or_stop_flag, ~r.scl_oe_n, r.rxack, 2'b00, r.dir, r.ap};
            A_SLAVE_OWN_ADDRESS: n.rdata = r.slave_own_address;
            A_SLAVE_DATA_REG: n.rdata = r.slave_data_reg;
            A_SMASK: n.rdata = r.smask;
            default: n.rdata = 8'h00;
         endcase
      end

      // software clears first, so hardware sets below win
      if (rd_master_data_reg) begin
         n.master_read_flag = 1'b0;
         n.master_write_flag = 1'b0;
         // smart mode only auto-acks; a nack needs an explicit command
         if (r.mctrl[B_SMART_MODE_EN] && !r.mack && m_ok) begin
            n.ack_go = 1'b1;
         end
      end
      if (reg_wr) begin
         unique case (reg_addr)
            A_BUS_TIMING: n.timing = reg_wdata;
            A_DEBUG_RUN: n.dbg = reg_wdata;
            A_MCTRL_ONE: n.mctrl = reg_wdata;
            A_MCTRL_TWO: begin
               n.mack = reg_wdata[B_ACK_ACTION];
               n.flush = m_ok && reg_wdata[B_FLUSH];
               if (reg_wdata[1:0] != 2'h0) begin
                  n.master_read_flag = 1'b0;
                  n.master_write_flag = 1'b0;
               end
               if (m_ok && reg_wdata[1:0] != 2'h0) begin
                  n.ack_go = 1'b1;
               end
               n.rep_go = m_ok && reg_wdata[1:0] == CMD_REPEAT_START_CMD;
               n.stop_go = m_ok && reg_wdata[1:0] == CMD_STOP;
            end
            A_MASTER_STATUS_REG: begin
               n.master_read_flag = r.master_read_flag & ~reg_wdata[B_RIF];
               n.master_write_flag = r.master_write_flag & ~reg_wdata[B_WIF];
            end
            A_MASTER_BAUD_DIVIDER: n.master_baud_divider = reg_wdata;
            A_MASTER_TARGET_ADDRESS: begin
               n.master_target_address = reg_wdata;
               n.master_read_flag = 1'b0;
               n.master_write_flag = 1'b0;
               n.addr_go = m_ok;
            end
            A_MASTER_DATA_REG: begin
               n.master_data_reg = reg_wdata;
               n.master_read_flag = 1'b0;
               n.master_write_flag = 1'b0;
            end
            A_SCTRL_ONE: n.sctrl = reg_wdata;
            A_SCTRL_TWO: begin
               n.sack = reg_wdata[B_ACK_ACTION];
               if (reg_wdata[1:0] != 2'h0) begin
                  n.slave_data_flag = 1'b0;
                  n.addr_or_stop_flag = 1'b0;
               end
               if (reg_wdata[1:0] == CMD_COMPLETE) begin
                  n.st = S_WAIT;
               end
            end
            A_SLAVE_STATUS_REG: begin
               n.slave_data_flag = r.slave_data_flag & ~reg_wdata[B_DIF];
               n.addr_or_stop_flag = r.addr_or_stop_flag & ~reg_wdata[B_ADDR_OR_STOP_FLAG];
            end
            A_SLAVE_OWN_ADDRESS: n.slave_own_address = reg_wdata;
            A_SLAVE_DATA_REG: begin
               n.slave_data_reg = reg_wdata;
               if (r.st == S_TX) begin
                  n.shift = reg_wdata;
               end
            end
            A_SMASK: n.smask = reg_wdata;
            default: ;
         endcase
      end
      if (r.sctrl[B_SMART_MODE_EN] && (wr_slave_data_reg || rd_slave_data_reg)) begin
         n.slave_data_flag = 1'b0;
      end
      if (mst_rx_done && r.mctrl[B_EN]) begin
         n.master_read_flag = 1'b1;
      end
      if (mst_tx_done && r.mctrl[B_EN]) begin
         n.master_write_flag = 1'b1;
      end

      // byte engine on synchronised scl edges, independent of sleep
      if (!r.sctrl[B_EN]) begin
         n.st = S_IDLE;
      end else if (start_det) begin
         n.st = S_ADDR;
         n.bits = 4'h0;
         if (sleep_active && !sys_clk_ready) begin
            n.wake_hold = 1'b1;
         end
      end else if (stop_det) begin
         if (r.st != S_IDLE) begin
            n.addr_or_stop_flag = 1'b1;
            n.ap = 1'b0;
         end
         n.st = S_IDLE;
      end else begin
         unique case (r.st)
            S_IDLE: ;
            S_WAIT: ;
            S_ADDR, S_RX: begin
               if (scl_rise) begin
                  n.shift = {r.shift[6:0], sda_s};
                  n.bits = r.bits + 4'h1;
               end else if (scl_fall && r.bits == BITS_BYTE) begin
                  if (r.st == S_RX) begin
                     n.slave_data_reg = r.shift;
                     n.slave_data_flag = 1'b1;
                     n.st = S_RACK;
                  end else if (addr_hit) begin
                     n.addr_or_stop_flag = 1'b1;
                     n.ap = 1'b1;
                     n.dir = r.shift[0];
                     n.st = S_AACK;
                  end else begin
                     n.st = S_IDLE;
                  end
               end
            end
            S_AACK: begin
               if (scl_fall) begin
                  n.bits = 4'h0;
                  if (r.dir) begin
                     n.slave_data_flag = 1'b1;
                     n.st = S_TX;
                  end else begin
                     n.st = S_RX;
                  end
               end
            end
            S_RACK: begin
               if (scl_fall) begin
                  n.bits = 4'h0;
                  n.st = r.sack ? S_WAIT : S_RX;
               end
            end
            S_TX: begin
               if (scl_fall) begin
                  if (r.bits == TX_LAST) begin
                     n.st = S_TACK;
                  end else begin
                     n.shift = {r.shift[6:0], 1'b1};
                     n.bits = r.bits + 4'h1;
                  end
               end
            end
            S_TACK: begin
               if (scl_rise) begin
                  n.rxack = sda_s;
               end else if (scl_fall) begin
                  n.slave_data_flag = 1'b1;
                  n.bits = 4'h0;
                  n.st = r.rxack ? S_WAIT : S_TX;
               end
            end
         endcase
      end
      if (r.wake_hold && sys_clk_ready) begin
         n.wake_hold = 1'b0;
      end

      // sda level the slave wants during the low phase
      unique case (r.st)
         S_AACK: want_oe_n = 1'b0;
         S_RACK: want_oe_n = r.sack;
         S_TX: want_oe_n = r.shift[7];
         default: want_oe_n = 1'b1;
      endcase
      // hold delay after scl falls, then setup before scl may rise
      if (scl_fall) begin
         n.hcnt = hold_cyc;
         n.scnt = 8'h00;
      end else if (!scl_s) begin
         if (r.hcnt != 8'h00) begin
            n.hcnt = r.hcnt - 8'h01;
         end else if (r.sda_oe_n != want_oe_n) begin
            n.sda_oe_n = want_oe_n;
            n.scnt = setup_cyc;
         end else if (r.scnt != 8'h00) begin
            n.scnt = r.scnt - 8'h01;
         end
      end
      if (r.st == S_IDLE || r.st == S_WAIT || !r.sctrl[B_EN]) begin
         n.sda_oe_n = 1'b1;
      end
      // stretch until flags are serviced and sda has settled
      hold_req = (r.slave_data_flag || r.addr_or_stop_flag) && r.st != S_IDLE && r.st != S_WAIT;
      // a pending sda change keeps the hold, else scl glitches high for a cycle
      if (r.wake_hold || (!scl_s && r.sctrl[B_EN] && (hold_req ||
            r.hcnt != 8'h00 || r.scnt != 8'h00 || r.sda_oe_n != want_oe_n))) begin
         n.scl_oe_n = 1'b0;
      end else begin
         n.scl_oe_n = 1'b1;
      end

      // one combined request per vector
      n.s_irq = n.slave_data_flag | n.addr_or_stop_flag;
      n.m_irq = n.master_read_flag | n.master_write_flag;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
         r.timing <= RST_VAL;
         r.st <= S_IDLE;
         r.scl_p <= 1'b1;
         r.sda_p <= 1'b1;
         r.sda_oe_n <= 1'b1;
         r.scl_oe_n <= 1'b1;
      end else begin
         r <= n;
      end
   end

   assign reg_rdata = r.rdata;
   // open drain: only the enables move, the level stays low
   assign scl_out = r.mack & 1'b0;
   assign sda_out = r.sack & 1'b0;
   assign scl_oe_n = r.scl_oe_n;
   assign sda_oe_n = r.sda_oe_n;
   assign mst_ack_go = r.ack_go;
   assign mst_ack_nack = r.mack;
   assign mst_repeat_start_cmd_go = r.rep_go;
   assign mst_stop_go = r.stop_go;
   assign mst_addr_go = r.addr_go;
   assign mst_flush = r.flush;
   assign fast_plus_mode = r.timing[B_FAST_PLUS_EN];
   assign slave_irq = r.s_irq;
   assign master_irq = r.m_irq;
endmodule : tws_top

/* include/tws_pkg.sv */
// constants, register map and state codes of the two-wire unit
package tws_pkg;
   localparam int unsigned CLK_NS = 4;
   localparam int unsigned REG_AW = 4;
   // register index = byte offset
   localparam logic [3:0] A_BUS_TIMING = 4'h0;
   localparam logic [3:0] A_RESERVED = 4'h1;
   localparam logic [3:0] A_DEBUG_RUN = 4'h2;
   localparam logic [3:0] A_MCTRL_ONE = 4'h3;
   localparam logic [3:0] A_MCTRL_TWO = 4'h4;
   localparam logic [3:0] A_MASTER_STATUS_REG = 4'h5;
   localparam logic [3:0] A_MASTER_BAUD_DIVIDER = 4'h6;
   localparam logic [3:0] A_MASTER_TARGET_ADDRESS = 4'h7;
   localparam logic [3:0] A_MASTER_DATA_REG = 4'h8;
   localparam logic [3:0] A_SCTRL_ONE = 4'h9;
   localparam logic [3:0] A_SCTRL_TWO = 4'ha;
   localparam logic [3:0] A_SLAVE_STATUS_REG = 4'hb;
   localparam logic [3:0] A_SLAVE_OWN_ADDRESS = 4'hc;
   localparam logic [3:0] A_SLAVE_DATA_REG = 4'hd;
   localparam logic [3:0] A_SMASK = 4'he;
   localparam logic [7:0] RST_VAL = 8'h00;
   // field positions
   localparam int unsigned B_FAST_PLUS_EN = 1;
   localparam int unsigned B_HOLD_LO = 2;
   localparam int unsigned B_SETUP = 4;
   localparam int unsigned B_EN = 0;
   localparam int unsigned B_SMART_MODE_EN = 1;
   localparam int unsigned B_ACK_ACTION = 2;
   localparam int unsigned B_FLUSH = 3;
   localparam int unsigned B_RIF = 7;
   localparam int unsigned B_WIF = 6;
   localparam int unsigned B_DIF = 7;
   localparam int unsigned B_ADDR_OR_STOP_FLAG = 6;
   // master and slave command codes
   localparam logic [1:0] CMD_REPEAT_START_CMD = 2'h1;
   localparam logic [1:0] CMD_COMPLETE = 2'h2;
   localparam logic [1:0] CMD_STOP = 2'h3;
   localparam logic [1:0] CMD_RESPONSE = 2'h3;
   // irq vector offsets, for software reference
   localparam logic [7:0] VEC_SLAVE = 8'h00;
   localparam logic [7:0] VEC_MASTER_SMALL = 8'h02;
   localparam logic [7:0] VEC_MASTER_LARGE = 8'h04;
   // sda timing
   localparam logic [7:0] SETUP_SHORT_CYC = 8'h04;
   localparam logic [7:0] SETUP_LONG_CYC = 8'h08;
   localparam int unsigned HOLD1_NS = 50;
   localparam int unsigned HOLD2_NS = 300;
   localparam int unsigned HOLD3_NS = 500;
   localparam logic [7:0] HOLD1_CYC = 8'((HOLD1_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] HOLD2_CYC = 8'((HOLD2_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] HOLD3_CYC = 8'((HOLD3_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] BITS_BYTE = 4'h8;
   localparam logic [3:0] TX_LAST = 4'h7;
   typedef enum logic [7:0] {
      S_IDLE = 8'h01,
      S_ADDR = 8'h02,
      S_AACK = 8'h04,
      S_RX = 8'h08,
      S_RACK = 8'h10,
      S_TX = 8'h20,
      S_TACK = 8'h40,
      S_WAIT = 8'h80
   } tws_state_t;
endpackage : tws_pkg

/* verification/tws_bus_master.sv */
// behavioural bus master on the two-wire lines, honours clock stretching
`timescale 1ns/1ps
module tws_bus_master (
   input wire logic clock,
   input wire logic scl,
   input wire logic sda,
   output logic scl_low,
   output logic sda_low
);
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   task automatic tk(input int n);
      repeat (n) @(posedge clock);
   endtask : tk
   // bounded so a line stuck low cannot hang the run
   task automatic rise();
      int k;
      k = 0;
      scl_low <= 1'b0;
      @(posedge clock);
      while (!scl && k < 20000) begin
         @(posedge clock);
         k++;
      end
   endtask : rise
   task automatic put_bit(input logic b);
      sda_low <= !b;
      tk(5);
      rise();
      tk(9);
      scl_low <= 1'b1;
      tk(5);
   endtask : put_bit
   task automatic get_bit(output logic b);
      sda_low <= 1'b0;
      tk(5);
      rise();
      tk(5);
      b = sda;
      tk(4);
      scl_low <= 1'b1;
      tk(5);
   endtask : get_bit
   task automatic start_cond();
      sda_low <= 1'b0;
      tk(5);
      rise();
      tk(5);
      sda_low <= 1'b1;
      tk(10);
      scl_low <= 1'b1;
      tk(5);
   endtask : start_cond
   task automatic stop_cond();
      sda_low <= 1'b1;
      tk(5);
      rise();
      tk(5);
      sda_low <= 1'b0;
      tk(10);
   endtask : stop_cond
   task automatic send_byte(input logic [7:0] d, output logic ack_n);
      for (int i = 7; i >= 0; i--) put_bit(d[i]);
      get_bit(ack_n);
   endtask : send_byte
   task automatic recv_byte(output logic [7:0] d, input logic ack_n);
      for (int i = 7; i >= 0; i--) get_bit(d[i]);
      put_bit(ack_n);
   endtask : recv_byte
endmodule : tws_bus_master

/* verification/tws_top_assertions.sv */
// concurrent checks on the ports of the two-wire unit
`timescale 1ns/1ps
module tws_top_chk
   import tws_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [REG_AW-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic sleep_active,
   input wire logic mst_rx_done,
   input wire logic mst_tx_done,
   input wire logic mst_ack_go,
   input wire logic mst_ack_nack,
   input wire logic mst_repeat_start_cmd_go,
   input wire logic mst_stop_go,
   input wire logic mst_addr_go,
   input wire logic mst_flush,
   input wire logic fast_plus_mode,
   input wire logic slave_irq,
   input wire logic master_irq
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   wire logic acc = reg_wr | reg_rd;
   wire logic mt_wr = reg_wr && (reg_addr == A_MCTRL_TWO);
   wire logic stop_wr = mt_wr && (reg_wdata[1:0] == CMD_STOP) && !sleep_active;
   wire logic ack_why = (mt_wr && (reg_wdata[1:0] != 2'h0))
      || (reg_rd && (reg_addr == A_MASTER_DATA_REG) && !mst_ack_nack);
   wire logic mdone = mst_rx_done | mst_tx_done;
   wire logic fp_wr = reg_wr && (reg_addr == A_BUS_TIMING);
   wire logic fp_bit = reg_wdata[B_FAST_PLUS_EN];
   wire logic go_any = mst_ack_go | mst_repeat_start_cmd_go | mst_stop_go | mst_addr_go | mst_flush;
   property p_rsvd;
      reg_rd && (reg_addr == A_RESERVED) |=> reg_rdata == 8'h00;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved read not zero");
   property p_cmd_zero;
      reg_rd && (reg_addr == A_MCTRL_TWO) |=> reg_rdata[1:0] == 2'h0;
   endproperty
   a_cmd_zero: assert property (p_cmd_zero) else $error("command field read nonzero");
   property p_stop;
      mst_stop_go |-> $past(stop_wr);
   endproperty
   a_stop: assert property (p_stop) else $error("stop pulse without stop command");
   property p_ack;
      mst_ack_go |-> $past(ack_why);
   endproperty
   a_ack: assert property (p_ack) else $error("ack pulse without cause");
   property p_sleep;
      sleep_active && $past(sleep_active) |-> !go_any;
   endproperty
   a_sleep: assert property (p_sleep) else $error("master strobe during sleep");
   property p_mirq;
      $rose(master_irq) |-> $past(mdone, 1) || $past(mdone, 2);
   endproperty
   a_mirq: assert property (p_mirq) else $error("master irq without event");
   property p_sirq;
      $fell(slave_irq) |-> $past(acc, 1) || $past(acc, 2);
   endproperty
   a_sirq: assert property (p_sirq) else $error("slave irq dropped on its own");
   property p_fp;
      $changed(fast_plus_mode) |-> $past(fp_wr) && (fast_plus_mode == $past(fp_bit));
   endproperty
   a_fp: assert property (p_fp) else $error("fast-plus changed without write");
endmodule : tws_top_chk
bind tws_top tws_top_chk chk_u (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata, .sleep_active, .mst_rx_done, .mst_tx_done, .mst_ack_go, .mst_ack_nack,
   .mst_repeat_start_cmd_go, .mst_stop_go, .mst_addr_go, .mst_flush, .fast_plus_mode, .slave_irq,
   .master_irq);

/* verification/tws_top_test.sv */
// bench: registers, master strobes, slave transfers through the bus model
`timescale 1ns/1ps
module tws_top_test
   import tws_pkg::*;
;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0, reg_rd = 1'b0, sleep_active = 1'b0, sys_clk_ready = 1'b1;
   logic mst_rx_done = 1'b0, mst_tx_done = 1'b0;
   logic [7:0] reg_rdata, v, d;
   logic scl_out, scl_oe_n, sda_out, sda_oe_n, mst_ack_go, mst_ack_nack, mst_repeat_start_cmd_go;
   logic mst_stop_go, mst_addr_go, mst_flush, fast_plus_mode, slave_irq, master_irq;
   logic scl_low, sda_low, an;
   // pull-ups: line is high unless someone pulls
   wire logic scl_in = !(scl_low || !scl_oe_n);
   wire logic sda_in = !(sda_low || !sda_oe_n);
   int num_errors = 0, n_compared = 0, cyc = 0, n_ack = 0, n_rs = 0, n_stop = 0;
   int n_ad = 0, n_fl = 0;
   int a0, r0, s0;
   always #2 clock = ~clock;
   tws_top dut_u (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .scl_in, .scl_out, .scl_oe_n, .sda_in, .sda_out, .sda_oe_n, .sleep_active,
      .sys_clk_ready, .mst_rx_done, .mst_tx_done, .mst_ack_go, .mst_ack_nack,
      .mst_repeat_start_cmd_go, .mst_stop_go, .mst_addr_go, .mst_flush, .fast_plus_mode,
      .slave_irq, .master_irq);
   tws_bus_master bm_u (.clock, .scl(scl_in), .sda(sda_in), .scl_low, .sda_low);
   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up
   always @(posedge clock) begin
      cyc++;
      n_ack += (mst_ack_go === 1'b1);
      n_rs += (mst_repeat_start_cmd_go === 1'b1);
      n_stop += (mst_stop_go === 1'b1);
      n_ad += (mst_addr_go === 1'b1);
      n_fl += (mst_flush === 1'b1);
      if (cyc == 40000) begin
         num_errors++;
         wrap_up();
      end
   end
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         num_errors++;
      end
   endtask : chk
   // a clock edge passes after each strobe so the next call never re-drives it
   task automatic wr(input logic [3:0] a, input logic [7:0] w);
      reg_addr <= a;
      reg_wdata <= w;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      @(posedge clock);
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] r);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 r = reg_rdata;
      @(posedge clock);
   endtask : rd
   task automatic w_irq();
      int k;
      k = 0;
      while (slave_irq !== 1'b1 && k < 20000) begin
         @(posedge clock);
         k++;
      end
      chk("slave_irq", 8'h01, {7'h0, slave_irq});
   endtask : w_irq
   initial begin
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      rd(A_BUS_TIMING, v); chk("timing reset", 8'h00, v);
      wr(A_RESERVED, 8'hff); rd(A_RESERVED, v); chk("reserved", 8'h00, v);
      rd(4'hf, v); chk("unmapped", 8'h00, v);
      wr(A_BUS_TIMING, 8'h1e); rd(A_BUS_TIMING, v); chk("timing", 8'h1e, v);
      chk("fast plus", 8'h01, {7'h0, fast_plus_mode});
      wr(A_BUS_TIMING, 8'h00);
      $display("register test done");
      wr(A_MCTRL_ONE, 8'h03);
      mst_rx_done <= 1'b1; @(posedge clock); mst_rx_done <= 1'b0; repeat (3) @(posedge clock);
      chk("master_irq", 8'h01, {7'h0, master_irq});
      rd(A_MASTER_STATUS_REG, v); chk("master_status_reg", 8'h80, v & 8'hc0);
      a0 = n_ack; rd(A_MASTER_DATA_REG, v); repeat (2) @(posedge clock);
      chk("smart ack", 8'(a0 + 1), 8'(n_ack));
      chk("master_irq off", 8'h00, {7'h0, master_irq});
      wr(A_MCTRL_TWO, 8'h04);
      mst_tx_done <= 1'b1; @(posedge clock); mst_tx_done <= 1'b0; @(posedge clock);
      a0 = n_ack; rd(A_MASTER_DATA_REG, v); repeat (2) @(posedge clock);
      chk("smart nack", 8'(a0), 8'(n_ack));
      chk("nack level", 8'h01, {7'h0, mst_ack_nack});
      a0 = n_ad;
      r0 = n_fl;
      wr(A_MASTER_TARGET_ADDRESS, 8'ha0);
      wr(A_MCTRL_TWO, 8'h08);
      repeat (2) @(posedge clock);
      chk("addr strobe", 8'(a0 + 1), 8'(n_ad));
      chk("flush strobe", 8'(r0 + 1), 8'(n_fl));
      chk("line levels", 8'h00, {6'h0, scl_out, sda_out});
      for (int i = 1; i < 4; i++) begin
         a0 = n_ack; r0 = n_rs; s0 = n_stop;
         wr(A_MCTRL_TWO, 8'(i)); repeat (2) @(posedge clock);
         chk("cmd ack", 8'(a0 + 1), 8'(n_ack));
         chk("cmd repeat_start_cmd", 8'(r0 + (i == 1)), 8'(n_rs));
         chk("cmd stop", 8'(s0 + (i == 3)), 8'(n_stop));
      end
      rd(A_MCTRL_TWO, v); chk("cmd reads zero", 8'h00, v & 8'h03);
      sleep_active <= 1'b1;
      s0 = n_stop;
      r0 = n_fl;
      wr(A_MCTRL_TWO, 8'h0b);
      repeat (2) @(posedge clock);
      chk("stop in sleep", 8'(s0), 8'(n_stop));
      chk("flush in sleep", 8'(r0), 8'(n_fl));
      $display("master test done");
      wr(A_SLAVE_OWN_ADDRESS, 8'h50); wr(A_SCTRL_ONE, 8'h03);
      fork
         begin
            bm_u.start_cond(); bm_u.send_byte(8'h50, an); chk("addr ack", 8'h00, an);
            bm_u.send_byte(8'ha5, an); chk("data ack", 8'h00, an);
            bm_u.send_byte(8'h3c, an); chk("data nack", 8'h01, an);
            bm_u.send_byte(8'h0f, an); chk("after nack", 8'h01, an);
            bm_u.stop_cond();
         end
         begin
            w_irq(); rd(A_SLAVE_STATUS_REG, v); chk("addr flag", 8'h61, v & 8'he3);
            wr(A_SLAVE_STATUS_REG, 8'hc0); repeat (3) @(posedge clock);
            w_irq(); rd(A_SLAVE_DATA_REG, v); chk("rx byte", 8'ha5, v);
            repeat (3) @(posedge clock); chk("dif cleared", 8'h00, {7'h0, slave_irq});
            w_irq(); wr(A_SCTRL_TWO, 8'h04); rd(A_SLAVE_DATA_REG, v); chk("rx byte 2", 8'h3c, v);
         end
      join
      wr(A_SLAVE_STATUS_REG, 8'hc0); wr(A_SCTRL_TWO, 8'h00);
      $display("slave write test done");
      sys_clk_ready <= 1'b0;
      fork
         begin
            bm_u.start_cond(); bm_u.send_byte(8'h51, an); chk("addr ack", 8'h00, an);
            bm_u.recv_byte(d, 1'b1); chk("tx byte", 8'hc3, d);
            bm_u.recv_byte(d, 1'b1); chk("tx after nack", 8'hff, d);
            bm_u.stop_cond();
         end
         begin
            repeat (60) @(posedge clock);
            chk("wake stretch", 8'h00, {7'h0, scl_oe_n});
            sys_clk_ready <= 1'b1;
            w_irq(); rd(A_SLAVE_STATUS_REG, v); chk("read dir", 8'h03, v & 8'h03);
            wr(A_SLAVE_STATUS_REG, 8'h40); repeat (3) @(posedge clock);
            w_irq(); wr(A_SLAVE_DATA_REG, 8'hc3); repeat (3) @(posedge clock);
            chk("dif cleared", 8'h00, {7'h0, slave_irq});
            w_irq(); rd(A_SLAVE_STATUS_REG, v); chk("master nack", 8'h10, v & 8'h10);
            wr(A_SLAVE_STATUS_REG, 8'hc0);
         end
      join
      wr(A_SLAVE_STATUS_REG, 8'hc0);
      sleep_active <= 1'b0;
      $display("slave read test done");
      wrap_up();
   end
endmodule : tws_top_test
